// ===== oopc_pkg.sv
package oopc_pkg;
  localparam logic [16:0] OPT_BASE = 17'h00FE4;
  localparam logic [16:0] OPT_LAST = 17'h00FFC;
  localparam logic [16:0] PROG_BASE = 17'h01000;
  localparam logic [16:0] PROG_LAST = 17'h0FFFF;
  localparam int OPT_COUNT = 7;
  localparam logic [2:0] IDX_SYS = 3'h0;
  localparam logic [2:0] IDX_P01 = 3'h1;
  localparam logic [2:0] IDX_P36 = 3'h2;
  localparam logic [2:0] IDX_P9A = 3'h3;
  localparam logic [2:0] IDX_P4 = 3'h4;
  localparam logic [2:0] IDX_P7 = 3'h5;
  localparam logic [2:0] IDX_P8 = 3'h6;
  localparam int BIT_DUAL = 4;
  localparam int BIT_RSTOUT = 3;
  localparam int BIT_POR = 2;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [1:0] OSC_2P18 = 2'h3;
  localparam logic [1:0] OSC_2P16 = 2'h2;
  localparam logic [1:0] OSC_2P12 = 2'h1;
  localparam logic [1:0] OSC_RSVD = 2'h0;
  localparam logic [18:0] WAIT_2P18 = 19'h40000;
  localparam logic [18:0] WAIT_2P16 = 19'h10000;
  localparam logic [18:0] WAIT_2P12 = 19'h01000;
  localparam logic [15:0] IO_LAST = 16'h007F;
  localparam logic [15:0] VEC_BASE = 16'hFFC0;
  localparam logic [31:0] ADR_SYS = 32'h0000_0000;
  localparam logic [31:0] ADR_P01 = 32'h0000_0004;
  localparam logic [31:0] ADR_P36 = 32'h0000_0008;
  localparam logic [31:0] ADR_P9A = 32'h0000_000C;
  localparam logic [31:0] ADR_P4 = 32'h0000_0010;
  localparam logic [31:0] ADR_P7 = 32'h0000_0014;
  localparam logic [31:0] ADR_P8 = 32'h0000_0018;
  localparam logic [31:0] ADR_STAT = 32'h0000_001C;
  localparam logic [31:0] ADR_CTRL = 32'h0000_0020;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    LD_FETCH = 2'b00,
    LD_WAIT = 2'b01,
    LD_RUN = 2'b10
  } oopc_ld_type;
endpackage

// ===== oopc_wait.sv
`timescale 1ns/1ps
module oopc_wait
  import oopc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [1:0] osc_code,
  output logic busy
);
  logic [18:0] cnt_ff;
  logic [18:0] nxt_cnt;

  function automatic logic [18:0] wait_len(input logic [1:0] code);
    case (code)
      OSC_2P18: wait_len = WAIT_2P18;
      OSC_2P16: wait_len = WAIT_2P16;
      OSC_2P12: wait_len = WAIT_2P12;
      default: wait_len = WAIT_2P18;
    endcase
  endfunction

  // The wait runs regardless of clock source, so an external clock gets it too.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = wait_len(osc_code);
    end else if (cnt_ff != 19'h00000) begin
      nxt_cnt = cnt_ff - 19'h00001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 19'h00000;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != 19'h00000);

  property p_wait_load;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && start && osc_code == OSC_2P12) |=> (cnt_ff == WAIT_2P12);
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("Wait length not loaded for short code.");
  property p_wait_long;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && start && osc_code == OSC_2P18) |=> (cnt_ff == WAIT_2P18);
  endproperty
  a_wait_long: assert property (p_wait_long) else $error("Wait length not loaded for long code.");
  property p_wait_down;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && !start && busy) |=> (cnt_ff == $past(cnt_ff) - 19'h00001);
  endproperty
  a_wait_down: assert property (p_wait_down) else $error("Wait counter did not step down.");
endmodule

// ===== oopc_top.sv
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module oopc_top
  import oopc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic prog_mode,
  input wire logic [16:0] prog_addr,
  input wire logic [7:0] prog_din,
  input wire logic prog_we_n,
  input wire logic prog_oe_n,
  output logic [7:0] prog_dout,
  output logic prog_doe,
  input wire logic stop_release,
  input wire logic int_reset,
  input wire logic [15:0] cpu_addr,
  output logic cpu_run,
  output logic osc_wait,
  output logic dual_clock,
  output logic reset_out_en,
  output logic por_enable,
  output logic osc_reserved,
  output logic [1:0] osc_code,
  output logic [7:0] pullup_en_p0,
  output logic [7:0] pullup_en_p1,
  output logic [7:0] pullup_en_p3,
  output logic [7:0] pullup_en_p6,
  output logic [7:0] pullup_en_p9,
  output logic [7:0] pullup_en_pa,
  output logic [4:0] pullup_en_p4,
  output logic [7:0] pullup_en_p7,
  output logic [7:0] pullup_en_p8,
  output logic [1:0] mem_region
);
  import oopc_pkg::*;

  // Option storage, blank on reset; a real part keeps it in the PROM cells.
  logic [7:0] opt_ff [OPT_COUNT];
  logic [7:0] nxt_opt [OPT_COUNT];
  logic [7:0] cfg_ff [OPT_COUNT];
  logic [7:0] nxt_cfg [OPT_COUNT];
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  oopc_ld_type st_ff;
  oopc_ld_type nxt_st;
  logic [1:0] pm_sync_ff;
  logic [1:0] nxt_pm_sync;
  logic [26:0] nxt_pin_s1;
  logic [26:0] pin_s1_ff;
  logic [26:0] pin_s2_ff;
  logic [16:0] pin_addr;
  logic [7:0] pin_din;
  logic pin_we_n;
  logic pin_oe_n;
  logic [8*OPT_COUNT-1:0] opt_flat;
  logic [1:0] sr_sync_ff;
  logic [1:0] nxt_sr_sync;
  logic sr_prev_ff;
  logic nxt_sr_prev;
  logic wait_start;
  logic wait_busy;
  logic pm;
  logic prog_hit;
  logic [2:0] prog_idx;
  logic [7:0] prog_rd_ff;
  logic [7:0] nxt_prog_rd;
  logic prog_doe_ff;
  logic nxt_prog_doe;
  logic bus_wr_ff;
  logic nxt_bus_wr;
  logic [31:0] bus_addr_ff;
  logic [31:0] nxt_bus_addr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic reload_req;
  logic addr_phase;

  // Only addresses 00FE4H..00FFCH on a four-byte stride name an option byte.
  function automatic logic opt_hit(input logic [16:0] a);
    opt_hit = (a >= OPT_BASE) && (a <= OPT_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] opt_index(input logic [16:0] a);
    logic [16:0] d;
    d = a - OPT_BASE;
    opt_index = d[4:2];
  endfunction

  function automatic logic [7:0] pair_spread(input logic [3:0] b);
    pair_spread = {~b[3], ~b[3], ~b[2], ~b[2], ~b[1], ~b[1], ~b[0], ~b[0]};
  endfunction

  assign pm = pm_sync_ff[1];
  // Programmer pins come from another clock, so they pass two flops; the programmer holds each phase long enough.
  assign nxt_pin_s1 = {prog_addr, prog_din, prog_we_n, prog_oe_n};
  assign {pin_addr, pin_din, pin_we_n, pin_oe_n} = pin_s2_ff;
  assign prog_hit = opt_hit(pin_addr);
  assign prog_idx = opt_index(pin_addr);
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Programmer port: only writes into the option window are kept; the program
  // array itself lives outside this block. No identifier read exists.
  always_comb begin
    for (int i = 0; i < OPT_COUNT; i++) begin
      nxt_opt[i] = opt_ff[i];
    end
    nxt_prog_rd = prog_rd_ff;
    nxt_prog_doe = 1'b0;
    if (pm) begin
      if (!pin_we_n && prog_hit) begin
        nxt_opt[prog_idx] = pin_din;
      end
      if (!pin_oe_n && pin_we_n) begin
        nxt_prog_doe = 1'b1;
        nxt_prog_rd = prog_hit ? opt_ff[prog_idx] : BLANK_BYTE;
      end
    end
    if (!pm && bus_wr_ff) begin
      case (bus_addr_ff)
        ADR_SYS: nxt_opt[IDX_SYS] = hwdata[7:0];
        ADR_P01: nxt_opt[IDX_P01] = hwdata[7:0];
        ADR_P36: nxt_opt[IDX_P36] = hwdata[7:0];
        ADR_P9A: nxt_opt[IDX_P9A] = hwdata[7:0];
        ADR_P4: nxt_opt[IDX_P4] = hwdata[7:0];
        ADR_P7: nxt_opt[IDX_P7] = hwdata[7:0];
        ADR_P8: nxt_opt[IDX_P8] = hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Loader: after reset every option byte is copied into the decode latch one
  // per cycle, then, if the BIT_POR bit is set, the oscillation wait runs before the CPU may fetch.
  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    for (int i = 0; i < OPT_COUNT; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    wait_start = 1'b0;
    case (st_ff)
      LD_FETCH: begin
        nxt_cfg[idx_ff] = opt_ff[idx_ff];
        if (idx_ff == 3'(OPT_COUNT - 1)) begin
          nxt_st = LD_WAIT;
          nxt_idx = 3'h0;
          wait_start = cfg_ff[IDX_SYS][BIT_POR] || (idx_ff == IDX_SYS && opt_ff[IDX_SYS][BIT_POR]) ? 1'b1 : 1'b0;
        end else begin
          nxt_idx = idx_ff + 3'h1;
        end
      end
      // A restart leaves the wait for a new fetch; a count already running is not cleared and runs out unless the fetch end starts a new wait over it.
      LD_WAIT: begin
        if (reload_req || int_reset) begin
          nxt_st = LD_FETCH;
        end else if (!wait_busy) begin
          nxt_st = LD_RUN;
        end
      end
      LD_RUN: begin
        if (reload_req || int_reset) begin
          nxt_st = LD_FETCH;
        end else if (sr_prev_ff == 1'b0 && sr_sync_ff[1] == 1'b1) begin
          nxt_st = LD_WAIT;
          wait_start = 1'b1;
        end
      end
      default: begin
        nxt_st = LD_FETCH;
        nxt_idx = 3'h0;
      end
    endcase
  end

  assign nxt_pm_sync = {pm_sync_ff[0], prog_mode};
  assign nxt_sr_sync = {sr_sync_ff[0], stop_release};
  assign nxt_sr_prev = sr_sync_ff[1];
  assign reload_req = !pm && bus_wr_ff && (bus_addr_ff == ADR_CTRL) && hwdata[0];

  // AHB-Lite slave with zero wait states; unmapped reads return zero.
  assign nxt_bus_wr = addr_phase && hwrite;
  assign nxt_bus_addr = addr_phase ? haddr : bus_addr_ff;
  always_comb begin
    nxt_rdata = rdata_ff;
    if (addr_phase && !hwrite) begin
      case (haddr)
        ADR_SYS: nxt_rdata = {24'h000000, opt_ff[IDX_SYS]};
        ADR_P01: nxt_rdata = {24'h000000, opt_ff[IDX_P01]};
        ADR_P36: nxt_rdata = {24'h000000, opt_ff[IDX_P36]};
        ADR_P9A: nxt_rdata = {24'h000000, opt_ff[IDX_P9A]};
        ADR_P4: nxt_rdata = {24'h000000, opt_ff[IDX_P4]};
        ADR_P7: nxt_rdata = {24'h000000, opt_ff[IDX_P7]};
        ADR_P8: nxt_rdata = {24'h000000, opt_ff[IDX_P8]};
        ADR_STAT: nxt_rdata = {28'h0000000, osc_reserved, pm, wait_busy, cpu_run};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < OPT_COUNT; i++) begin
        opt_ff[i] <= BLANK_BYTE;
        cfg_ff[i] <= BLANK_BYTE;
      end
      idx_ff <= 3'h0;
      st_ff <= LD_FETCH;
      pm_sync_ff <= 2'h0;
      pin_s1_ff <= {17'h00000, 8'h00, 1'b1, 1'b1};
      pin_s2_ff <= {17'h00000, 8'h00, 1'b1, 1'b1};
      sr_sync_ff <= 2'h0;
      sr_prev_ff <= 1'b0;
      prog_rd_ff <= BLANK_BYTE;
      prog_doe_ff <= 1'b0;
      bus_wr_ff <= 1'b0;
      bus_addr_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
    end else if (clk_en) begin
      opt_ff <= nxt_opt;
      cfg_ff <= nxt_cfg;
      idx_ff <= nxt_idx;
      st_ff <= nxt_st;
      pm_sync_ff <= nxt_pm_sync;
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= pin_s1_ff;
      sr_sync_ff <= nxt_sr_sync;
      sr_prev_ff <= nxt_sr_prev;
      prog_rd_ff <= nxt_prog_rd;
      prog_doe_ff <= nxt_prog_doe;
      bus_wr_ff <= nxt_bus_wr;
      bus_addr_ff <= nxt_bus_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  oopc_wait oopc_wait_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .start(wait_start),
    .osc_code(cfg_ff[IDX_SYS][1:0]),
    .busy(wait_busy)
  );

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign prog_dout = prog_rd_ff;
  assign prog_doe = prog_doe_ff;
  assign cpu_run = (st_ff == LD_RUN) && !pm;
  assign osc_wait = wait_busy;

  // Decoded settings come only from the latch, so PROM writes take effect at
  // the next reset or reload, never mid-run. Bits 7..5 of the system and port 4 bytes are not decoded.
  assign dual_clock = cfg_ff[IDX_SYS][BIT_DUAL];
  assign reset_out_en = cfg_ff[IDX_SYS][BIT_RSTOUT];
  assign por_enable = cfg_ff[IDX_SYS][BIT_POR];
  assign osc_code = cfg_ff[IDX_SYS][1:0];
  assign osc_reserved = (cfg_ff[IDX_SYS][1:0] == OSC_RSVD);
  assign pullup_en_p0 = pair_spread(cfg_ff[IDX_P01][3:0]);
  assign pullup_en_p1 = pair_spread(cfg_ff[IDX_P01][7:4]);
  assign pullup_en_p3 = pair_spread(cfg_ff[IDX_P36][3:0]);
  assign pullup_en_p6 = pair_spread(cfg_ff[IDX_P36][7:4]);
  assign pullup_en_p9 = pair_spread(cfg_ff[IDX_P9A][3:0]);
  assign pullup_en_pa = pair_spread(cfg_ff[IDX_P9A][7:4]);
  assign pullup_en_p4 = ~cfg_ff[IDX_P4][4:0];
  assign pullup_en_p7 = ~cfg_ff[IDX_P7];
  assign pullup_en_p8 = ~cfg_ff[IDX_P8];

  // Region of the CPU address: 0 I/O, 1 data, 2 program, 3 vector tables.
  assign mem_region = (cpu_addr <= IO_LAST) ? 2'h0 :
                      (cpu_addr >= VEC_BASE) ? 2'h3 :
                      (cpu_addr >= PROG_BASE[15:0]) ? 2'h2 : 2'h1;

  property p_no_run_in_wait;
    @(posedge hclk) disable iff (!hresetn) wait_busy |-> !cpu_run;
  endproperty
  a_no_run_in_wait: assert property (p_no_run_in_wait) else $error("CPU ran during oscillation wait.");
  property p_stop_wait;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && st_ff == LD_RUN && !int_reset && !reload_req && !sr_prev_ff && sr_sync_ff[1])
      |=> ##1 wait_busy;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("No wait after stop release.");
  property p_no_id;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && pm && !pin_oe_n && pin_we_n && !prog_hit) |=> (prog_dout == BLANK_BYTE);
  endproperty
  a_no_id: assert property (p_no_id) else $error("Outside option window a non-blank byte was read.");
  // Packed copy of the store, so the stride check watches one vector.
  always_comb begin
    for (int i = 0; i < OPT_COUNT; i++) begin
      opt_flat[8*i +: 8] = opt_ff[i];
    end
  end
  property p_stride;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && pm && !pin_we_n && pin_addr[1:0] != 2'h0) |=> $stable(opt_flat);
  endproperty
  a_stride: assert property (p_stride) else $error("Option written off the four-byte stride.");
  property p_dual;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && st_ff == LD_FETCH && idx_ff == IDX_SYS) |=> (dual_clock == $past(opt_ff[IDX_SYS][BIT_DUAL]));
  endproperty
  a_dual: assert property (p_dual) else $error("Clock system select wrong.");
  property p_rstout;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && st_ff == LD_FETCH && idx_ff == IDX_SYS)
      |=> (reset_out_en == $past(opt_ff[IDX_SYS][BIT_RSTOUT]) && por_enable == $past(opt_ff[IDX_SYS][BIT_POR]));
  endproperty
  a_rstout: assert property (p_rstout) else $error("Reset output or power-on select wrong.");
  property p_pair;
    @(posedge hclk) disable iff (!hresetn) pullup_en_p0[1] == pullup_en_p0[0] && pullup_en_p9[7] == pullup_en_p9[6];
  endproperty
  a_pair: assert property (p_pair) else $error("Paired pull-ups disagree.");
  property p_hold;
    @(posedge hclk) disable iff (!hresetn) (st_ff == LD_RUN && $past(st_ff) == LD_RUN) |-> $stable(pullup_en_p7);
  endproperty
  a_hold: assert property (p_hold) else $error("Settings changed while running.");
  c_run: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cpu_run));
  c_prog: cover property (@(posedge hclk) disable iff (!hresetn) pm && !pin_we_n && prog_hit);
  c_stop: cover property (@(posedge hclk) disable iff (!hresetn) st_ff == LD_RUN ##1 st_ff == LD_WAIT);
endmodule

// ===== oopc_prog_model.sv
`timescale 1ns/1ps
module oopc_prog_model (
  input wire logic hclk,
  input wire logic [7:0] prog_dout,
  input wire logic prog_doe,
  output logic prog_mode,
  output logic [16:0] prog_addr,
  output logic [7:0] prog_din,
  output logic prog_we_n,
  output logic prog_oe_n
);
  initial begin
    prog_mode = 1'b0;
    prog_addr = 17'h00000;
    prog_din = 8'hA5;
    prog_we_n = 1'b1;
    prog_oe_n = 1'b1;
  end

  // The device samples these pins on its own clock, so every phase is held for several edges.
  task automatic pmode(input logic on);
    @(posedge hclk);
    prog_mode <= on;
    repeat (5) @(posedge hclk);
  endtask

  task automatic pwrite(input logic [16:0] a, input logic [7:0] d);
    @(posedge hclk);
    prog_addr <= a;
    prog_din <= d;
    repeat (4) @(posedge hclk);
    prog_we_n <= 1'b0;
    repeat (4) @(posedge hclk);
    prog_we_n <= 1'b1;
    repeat (4) @(posedge hclk);
    // A released data bus must not keep showing the last byte.
    prog_din <= ~d;
  endtask

  task automatic pread(input logic [16:0] a, output logic [7:0] d, output logic oe);
    @(posedge hclk);
    prog_addr <= a;
    repeat (4) @(posedge hclk);
    prog_oe_n <= 1'b0;
    repeat (6) @(posedge hclk);
    d = prog_dout;
    oe = prog_doe;
    prog_oe_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
endmodule

// ===== oopc_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module oopc_top_tb;
  import oopc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp, stop_release, int_reset;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, osc_code, mem_region;
  logic [2:0] hsize;
  logic prog_mode, prog_we_n, prog_oe_n, prog_doe, cpu_run, osc_wait, dual_clock, reset_out_en, por_enable;
  logic osc_reserved, clk_en;
  logic [16:0] prog_addr;
  logic [7:0] prog_din, prog_dout, pu_p0, pu_p1, pu_p3, pu_p6, pu_p9, pu_pa, pu_p7, pu_p8;
  logic [4:0] pu_p4;
  logic [15:0] cpu_addr;
  logic [15:0] ra [8] = '{16'h0000, 16'h007F, 16'h0080, 16'h0FFF, 16'h1000, 16'hFFBF, 16'hFFC0, 16'hFFFF};
  logic [1:0] rr [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  int errors = 0;
  int cmp_count = 0;
  assign hready = hreadyout;

  oopc_top oopc_top_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_din(prog_din),
    .prog_we_n(prog_we_n), .prog_oe_n(prog_oe_n), .prog_dout(prog_dout), .prog_doe(prog_doe),
    .stop_release(stop_release), .int_reset(int_reset), .cpu_addr(cpu_addr), .cpu_run(cpu_run),
    .osc_wait(osc_wait), .dual_clock(dual_clock), .reset_out_en(reset_out_en), .por_enable(por_enable),
    .osc_reserved(osc_reserved), .osc_code(osc_code), .pullup_en_p0(pu_p0), .pullup_en_p1(pu_p1),
    .pullup_en_p3(pu_p3), .pullup_en_p6(pu_p6), .pullup_en_p9(pu_p9), .pullup_en_pa(pu_pa),
    .pullup_en_p4(pu_p4), .pullup_en_p7(pu_p7), .pullup_en_p8(pu_p8), .mem_region(mem_region));

  oopc_prog_model oopc_prog_model_i (.hclk(hclk), .prog_dout(prog_dout), .prog_doe(prog_doe),
    .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_din(prog_din), .prog_we_n(prog_we_n),
    .prog_oe_n(prog_oe_n));

  initial begin
    forever #5 hclk = ~hclk;
  end

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout_hit;
    errors++;
    results();
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) timeout_hit();
      @(posedge hclk);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    `CHK(hresp, 1'b0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask

  // Counts on the falling edge so that the design's updates from the rising edge have landed.
  task automatic wait_run(input int bound, output int n);
    n = 0;
    while (cpu_run !== 1'b1) begin
      @(negedge hclk);
      n++;
      if (n > bound) timeout_hit();
    end
  endtask

  function automatic logic [7:0] pairs(input logic [3:0] v);
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r[2*i +: 2] = {2{~v[i]}};
    end
    return r;
  endfunction

  task automatic s_defaults;
    for (int i = 0; i < OPT_COUNT; i++) begin
      rdchk(ADR_SYS + 32'(4 * i), 32'h0000_00FF);
    end
    rdchk(32'h0000_0024, 32'h0000_0000);
    `CHK({pu_p0, pu_p1, pu_p3, pu_p6, pu_p9, pu_pa, pu_p4, pu_p7, pu_p8}, 69'h0);
    `CHK({dual_clock, reset_out_en, por_enable, osc_code, cpu_run}, 6'h3E);
  endtask

  task automatic s_wait;
    int n;
    wr(ADR_SYS, 32'h0000_00E5);
    rdchk(ADR_SYS, 32'h0000_00E5);
    `CHK(dual_clock, 1'b1);
    @(posedge hclk);
    int_reset <= 1'b1;
    repeat (2) @(posedge hclk);
    int_reset <= 1'b0;
    repeat (12) @(negedge hclk);
    `CHK({dual_clock, reset_out_en, por_enable, osc_code, osc_wait, cpu_run}, 7'b0010110);
    rdchk(ADR_STAT, 32'h0000_0002);
    wait_run(5000, n);
    `CHK(n > 4000 && n < 4100, 1'b1);
    rdchk(ADR_STAT, 32'h0000_0001);
    @(posedge hclk);
    stop_release <= 1'b1;
    n = 0;
    while (osc_wait !== 1'b1) begin
      @(negedge hclk);
      n++;
      if (n > 10) timeout_hit();
    end
    n = 0;
    while (osc_wait === 1'b1 && n < 5000) begin
      @(negedge hclk);
      n++;
    end
    `CHK(n > 4080 && n < 4110, 1'b1);
    @(posedge hclk);
    stop_release <= 1'b0;
  endtask

  task automatic s_pull;
    int n;
    wr(ADR_P01, 32'h0000_005A);
    wr(ADR_P36, 32'h0000_00C3);
    wr(ADR_P9A, 32'h0000_000F);
    wr(ADR_P4, 32'h0000_00FA);
    wr(ADR_P7, 32'h0000_003C);
    wr(ADR_P8, 32'h0000_0081);
    rdchk(ADR_P4, 32'h0000_00FA);
    `CHK(pu_p7, 8'h00);
    wr(ADR_CTRL, 32'h0000_0001);
    // A low clock enable must hold the loader where it stands, so no wait starts and port 7 stays unloaded.
    @(posedge hclk);
    clk_en <= 1'b0;
    repeat (20) @(negedge hclk);
    `CHK({osc_wait, pu_p7}, 9'h000);
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (12) @(negedge hclk);
    wait_run(5000, n);
    `CHK({pu_p0, pu_p1, pu_p3}, {pairs(4'hA), pairs(4'h5), pairs(4'h3)});
    `CHK({pu_p6, pu_p9, pu_pa}, {pairs(4'hC), pairs(4'hF), pairs(4'h0)});
    `CHK({pu_p4, pu_p7, pu_p8}, {~5'h1A, ~8'h3C, ~8'h81});
  endtask

  task automatic s_nopor;
    int n;
    wr(ADR_SYS, 32'h0000_0018);
    wr(ADR_CTRL, 32'h0000_0001);
    repeat (12) @(negedge hclk);
    wait_run(30, n);
    `CHK({dual_clock, reset_out_en, por_enable, osc_code, osc_reserved, osc_wait}, 7'b1100010);
    rdchk(ADR_STAT, 32'h0000_0009);
  endtask

  task automatic s_region;
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      cpu_addr <= ra[i];
      @(negedge hclk);
      `CHK(mem_region, rr[i]);
    end
  endtask

  task automatic s_prog;
    logic [7:0] d;
    logic oe;
    oopc_prog_model_i.pmode(1'b1);
    `CHK(cpu_run, 1'b0);
    wr(ADR_SYS, 32'h0000_0000);
    rdchk(ADR_SYS, 32'h0000_0018);
    oopc_prog_model_i.pwrite(17'h00FE4, 8'h1D);
    oopc_prog_model_i.pwrite(17'h00FE5, 8'h00);
    oopc_prog_model_i.pwrite(17'h00FF8, 8'h55);
    oopc_prog_model_i.pwrite(17'h01000, 8'h12);
    oopc_prog_model_i.pwrite(17'h0FFFF, 8'h34);
    oopc_prog_model_i.pread(17'h00FE4, d, oe);
    `CHK({oe, d}, 9'h11D);
    oopc_prog_model_i.pread(17'h00FF8, d, oe);
    `CHK({oe, d}, 9'h155);
    oopc_prog_model_i.pread(17'h00FE5, d, oe);
    `CHK({oe, d}, 9'h1FF);
    oopc_prog_model_i.pread(17'h00000, d, oe);
    `CHK({oe, d}, 9'h1FF);
    oopc_prog_model_i.pmode(1'b0);
    rdchk(ADR_SYS, 32'h0000_001D);
    rdchk(ADR_P7, 32'h0000_0055);
    rdchk(ADR_P01, 32'h0000_005A);
  endtask

  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stop_release = 1'b0;
    int_reset = 1'b0;
    cpu_addr = 16'h0000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    s_defaults();
    s_wait();
    s_pull();
    s_nopor();
    s_region();
    s_prog();
    results();
  end
endmodule
